// [rtl/nco_regs.vh]
// Register offsets, field positions, reset values and timing for the note credit output block.
`ifndef NCO_REGS_VH
`define NCO_REGS_VH

`define NCO_CLK_NS 4
`define NCO_TICK_NS 1000000
`define NCO_TICK_PRELOAD 18'h0_0002
`define NCO_VEND_MS 8'h64
`define NCO_PRE_100MS 8'h64
`define NCO_PRE_50MS 8'h32

`define NCO_A_CTRL 8'h00
`define NCO_A_PRESET 8'h04
`define NCO_A_PLOW 8'h08
`define NCO_A_PHIGH 8'h0C
`define NCO_A_PPD 8'h10
`define NCO_A_STATUS 8'h14
`define NCO_A_CHAN_BASE 8'h40
`define NCO_A_CHAN_TOP 8'h7C

`define NCO_CTRL_MODE 0
`define NCO_CTRL_HOLD 1

`define NCO_PRE_SEL_LOW 0
`define NCO_PRE_LOW_50 1
`define NCO_PRE_SEL_HIGH 2
`define NCO_PRE_HIGH_50 3
`define NCO_PRE_SEL_MULT 4
`define NCO_PRE_MULT_LSB 5
`define NCO_PRE_MULT_MSB 6

`define NCO_RST_PLOW 8'h32
`define NCO_RST_PHIGH 8'h32
`define NCO_RST_PPD 4'h1

`endif

// [rtl/nco_tick.v]
// Millisecond tick divider with a restart input that aligns the tick to a phase start.
`include "nco_regs.vh"

module nco_tick #(
  parameter TICK_CYC = `NCO_TICK_NS / `NCO_CLK_NS
) (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Control and tick.
  input wire restart,
  output reg tick_q
);

  localparam [31:0] TC_FULL = TICK_CYC - 1;
  localparam [17:0] TC_LAST = TC_FULL[17:0];

  reg [17:0] cnt_q;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 18'h0_0000;
      tick_q <= 1'b0;
    end else if (restart) begin
      // The preload covers the restart register and the tick register, so a phase of
      // n ms ends exactly n*TICK_CYC cycles after it starts.
      cnt_q <= `NCO_TICK_PRELOAD;
      tick_q <= 1'b0;
    end else if (cnt_q == TC_LAST) begin
      cnt_q <= 18'h0_0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 18'h0_0001;
      tick_q <= 1'b0;
    end
  end

endmodule

// [rtl/nco_core.v]
// Note credit output: parallel vend pulses, pulse-stream trains and credit hold.
//
// Contract
// - Parallel credit: 100 ms low pulse.
// - Parallel mode: four channels, own lines.
// - High block input refuses that channel.
// - All four blocked: dark bezel, reverse.
// - Busy low while handling a note.
// - Escrow enabled only while escrow low.
// - Pulse mode: per-channel pulse count trains.
// - Pulse mode supports sixteen channels.
// - Pulse train only on first line.
// - Channels above four refused only globally.
// - Credit hold: wait escrow toggle first.
// - One group per toggle until paid.
// - Busy low, blocked during hold payout.
// - Low time, high time, multiplier configurable.
// - Presets: 100/50 ms, multiplier 1-4.
// - No preset selected keeps custom settings.
// - Credit after stacking, then release busy.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`include "nco_regs.vh"

module nco_core #(
  parameter TICK_CYC = `NCO_TICK_NS / `NCO_CLK_NS
) (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // Transport side.
  input wire note_present,
  input wire transport_active,
  input wire note_stacked,
  input wire [3:0] note_chan,
  output reg [15:0] chan_accept_q,
  output reg bezel_on_q,
  output reg motor_reverse_q,
  output reg escrow_enable_q,
  // Host machine pins.
  input wire [3:0] channel_block_input,
  input wire escrow_in,
  output reg [3:0] credit_line_n_q,
  output reg busy_n_q
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PAR = 3'h1;
  localparam [2:0] ST_PLOW = 3'h2;
  localparam [2:0] ST_PHIGH = 3'h3;
  localparam [2:0] ST_WAIT = 3'h4;

  reg [2:0] state_q;
  reg mode_q;
  reg hold_q;
  reg [7:0] plow_q;
  reg [7:0] phigh_q;
  reg [3:0] ppd_q;
  reg [7:0] chan_val_q [0:15];
  reg [1:0] par_chan_q;
  reg [7:0] ms_q;
  reg [3:0] pulse_left_q;
  reg [7:0] group_left_q;
  reg esc_seen_low_q;
  reg restart_q;
  wire tick_raw;
  wire tick;
  wire all_blocked;
  wire esc_toggle;
  wire phase_end;
  integer i;
  integer k;

  assign all_blocked = &channel_block_input;
  assign esc_toggle = esc_seen_low_q & escrow_in;

  // Channel permission from the block inputs and the mode.
  function chan_ok;
    input [3:0] ch;
    input md;
    input [3:0] blk;
    begin
      if (&blk) begin
        chan_ok = 1'b0;
      end else if (ch[3:2] == 2'b00) begin
        chan_ok = ~blk[ch[1:0]];
      end else begin
        chan_ok = md;
      end
    end
  endfunction

  // Phase length in ms, never shorter than one.
  function [7:0] ms_len;
    input [7:0] v;
    begin
      ms_len = (v == 8'h00) ? 8'h01 : v;
    end
  endfunction

  nco_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(restart_q),
    .tick_q(tick_raw)
  );

  // A tick raised just before a restart belongs to the old phase and is dropped.
  assign tick = tick_raw & ~restart_q;
  assign phase_end = tick & (ms_q == 8'h01);

  // Configuration registers.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= 1'b0;
      hold_q <= 1'b0;
      plow_q <= `NCO_RST_PLOW;
      phigh_q <= `NCO_RST_PHIGH;
      ppd_q <= `NCO_RST_PPD;
      for (i = 0; i < 16; i = i + 1) begin
        chan_val_q[i] <= i[7:0] + 8'h01;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `NCO_A_CTRL: begin
          mode_q <= reg_wdata[`NCO_CTRL_MODE];
          hold_q <= reg_wdata[`NCO_CTRL_HOLD];
        end
        `NCO_A_PRESET: begin
          if (reg_wdata[`NCO_PRE_SEL_LOW]) begin
            plow_q <= reg_wdata[`NCO_PRE_LOW_50] ? `NCO_PRE_50MS : `NCO_PRE_100MS;
          end
          if (reg_wdata[`NCO_PRE_SEL_HIGH]) begin
            phigh_q <= reg_wdata[`NCO_PRE_HIGH_50] ? `NCO_PRE_50MS : `NCO_PRE_100MS;
          end
          if (reg_wdata[`NCO_PRE_SEL_MULT]) begin
            ppd_q <= {2'b00, reg_wdata[`NCO_PRE_MULT_MSB:`NCO_PRE_MULT_LSB]} + 4'h1;
          end
        end
        `NCO_A_PLOW: plow_q <= reg_wdata[7:0];
        `NCO_A_PHIGH: phigh_q <= reg_wdata[7:0];
        `NCO_A_PPD: ppd_q <= reg_wdata[3:0];
        default: begin
          if (reg_addr >= `NCO_A_CHAN_BASE && reg_addr <= `NCO_A_CHAN_TOP) begin
            chan_val_q[reg_addr[5:2]] <= reg_wdata[7:0];
          end
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `NCO_A_CTRL: reg_rdata_q <= {30'h0000_0000, hold_q, mode_q};
        `NCO_A_PLOW: reg_rdata_q <= {24'h00_0000, plow_q};
        `NCO_A_PHIGH: reg_rdata_q <= {24'h00_0000, phigh_q};
        `NCO_A_PPD: reg_rdata_q <= {28'h000_0000, ppd_q};
        `NCO_A_STATUS: begin
          reg_rdata_q <= {16'h0000, group_left_q, 2'b00, all_blocked, ~busy_n_q, 1'b0,
            state_q};
        end
        default: begin
          if (reg_addr >= `NCO_A_CHAN_BASE && reg_addr <= `NCO_A_CHAN_TOP) begin
            reg_rdata_q <= {24'h00_0000, chan_val_q[reg_addr[5:2]]};
          end else begin
            reg_rdata_q <= 32'h0000_0000;
          end
        end
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // Escrow line watch for credit hold.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      esc_seen_low_q <= 1'b0;
    end else if (state_q != ST_WAIT) begin
      esc_seen_low_q <= 1'b0;
    end else if (!escrow_in) begin
      esc_seen_low_q <= 1'b1;
    end else if (esc_toggle) begin
      esc_seen_low_q <= 1'b0;
    end
  end

  // Credit sequencer.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      par_chan_q <= 2'b00;
      ms_q <= 8'h00;
      pulse_left_q <= 4'h0;
      group_left_q <= 8'h00;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (note_stacked && chan_ok(note_chan, mode_q, channel_block_input)) begin
            restart_q <= 1'b1;
            if (!mode_q) begin
              par_chan_q <= note_chan[1:0];
              ms_q <= `NCO_VEND_MS;
              state_q <= ST_PAR;
            end else if (chan_val_q[note_chan] != 8'h00 && ppd_q != 4'h0) begin
              group_left_q <= chan_val_q[note_chan];
              pulse_left_q <= ppd_q;
              ms_q <= ms_len(plow_q);
              state_q <= hold_q ? ST_WAIT : ST_PLOW;
            end
          end
        end
        ST_PAR: begin
          if (phase_end) begin
            state_q <= ST_IDLE;
          end else if (tick) begin
            ms_q <= ms_q - 8'h01;
          end
        end
        ST_PLOW: begin
          if (phase_end) begin
            restart_q <= 1'b1;
            ms_q <= ms_len(phigh_q);
            state_q <= ST_PHIGH;
          end else if (tick) begin
            ms_q <= ms_q - 8'h01;
          end
        end
        ST_PHIGH: begin
          if (phase_end) begin
            restart_q <= 1'b1;
            ms_q <= ms_len(plow_q);
            if (pulse_left_q != 4'h1) begin
              pulse_left_q <= pulse_left_q - 4'h1;
              state_q <= ST_PLOW;
            end else begin
              pulse_left_q <= ppd_q;
              group_left_q <= group_left_q - 8'h01;
              if (group_left_q == 8'h01) begin
                state_q <= ST_IDLE;
              end else begin
                state_q <= hold_q ? ST_WAIT : ST_PLOW;
              end
            end
          end else if (tick) begin
            ms_q <= ms_q - 8'h01;
          end
        end
        ST_WAIT: begin
          if (esc_toggle) begin
            restart_q <= 1'b1;
            state_q <= ST_PLOW;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Host pins and transport controls.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      credit_line_n_q <= 4'hF;
      busy_n_q <= 1'b1;
      chan_accept_q <= 16'h0000;
      bezel_on_q <= 1'b0;
      motor_reverse_q <= 1'b0;
      escrow_enable_q <= 1'b0;
    end else begin
      credit_line_n_q <= 4'hF;
      if (state_q == ST_PAR) begin
        credit_line_n_q[par_chan_q] <= 1'b0;
      end else if (state_q == ST_PLOW) begin
        credit_line_n_q[0] <= 1'b0;
      end
      busy_n_q <= ~(transport_active | (state_q != ST_IDLE));
      for (k = 0; k < 16; k = k + 1) begin
        chan_accept_q[k] <= (state_q == ST_IDLE) &
          chan_ok(k[3:0], mode_q, channel_block_input);
      end
      bezel_on_q <= ~all_blocked;
      motor_reverse_q <= all_blocked & note_present;
      escrow_enable_q <= ~escrow_in;
    end
  end

endmodule

// [sim/nco_core_assertions.sv]
// Port-level assertions for the note credit output block.
module nco_core_checker #(
  parameter TICK_CYC = 10
) (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  // Transport side.
  input wire note_present,
  input wire transport_active,
  input wire note_stacked,
  input wire [3:0] note_chan,
  input wire [15:0] chan_accept_q,
  input wire bezel_on_q,
  input wire motor_reverse_q,
  input wire escrow_enable_q,
  // Host machine pins.
  input wire [3:0] channel_block_input,
  input wire escrow_in,
  input wire [3:0] credit_line_n_q,
  input wire busy_n_q
);
  localparam int PAR = 100 * TICK_CYC;
  logic [15:0] low_cnt_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Counts how long any of the upper three lines has been low.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) low_cnt_q <= 16'h0000;
    else if (&credit_line_n_q[3:1]) low_cnt_q <= 16'h0000;
    else low_cnt_q <= low_cnt_q + 16'h0001;
  end

  sequence s_take;
    note_stacked && chan_accept_q[note_chan];
  endsequence
  sequence s_busy_held;
    !busy_n_q [*2];
  endsequence

  AST_TAKE_BUSY: assert property (s_take |-> ##2 s_busy_held)
    else $error("busy not low after a credited note");
  AST_BLOCK_REFUSE: assert property (channel_block_input != 4'h0 |=>
    (chan_accept_q[3:0] & $past(channel_block_input)) == 4'h0)
    else $error("blocked channel still accepted");
  AST_ALL_BLOCKED: assert property (&channel_block_input |=> !bezel_on_q &&
    chan_accept_q == 16'h0000 && motor_reverse_q == $past(note_present))
    else $error("disabled state not entered");
  AST_ESCROW: assert property (1'b1 |=> escrow_enable_q != $past(escrow_in))
    else $error("escrow enable does not follow escrow input");
  AST_ONE_LINE: assert property ($onehot0(~credit_line_n_q))
    else $error("more than one credit line low");
  AST_LINE_BUSY: assert property (credit_line_n_q != 4'hF |-> !busy_n_q)
    else $error("credit line low while busy high");
  AST_PAR_WIDTH: assert property (!$past(sys_rst) && $rose(&credit_line_n_q[3:1]) |->
    low_cnt_q >= PAR - 1 && low_cnt_q <= PAR + 1)
    else $error("parallel credit pulse width wrong");
  AST_TRANSPORT_BUSY: assert property (transport_active |=> !busy_n_q)
    else $error("busy high while transport active");
endmodule

bind nco_core nco_core_checker #(.TICK_CYC(TICK_CYC)) nco_core_checker_inst (.sys_clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .note_present, .transport_active,
  .note_stacked, .note_chan, .chan_accept_q, .bezel_on_q, .motor_reverse_q, .escrow_enable_q,
  .channel_block_input, .escrow_in, .credit_line_n_q, .busy_n_q);

// [sim/nco_host_model.sv]
// Host machine model that times low pulses on the four credit lines.
module nco_host_model #(
  parameter int MIN_W = 2
) (
  // Clock.
  input wire sys_clk,
  // Credit lines.
  input wire [3:0] credit_line_n_q,
  // Pulse report.
  output logic pulse_seen,
  output logic [1:0] pulse_line,
  output int pulse_width
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [4];

  always @(posedge sys_clk) begin
    pulse_seen <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (credit_line_n_q[i] === 1'b0) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        if (cnt[i] >= MIN_W) begin
          pulse_seen <= 1'b1;
          pulse_line <= 2'(i);
          pulse_width <= cnt[i];
        end
        cnt[i] <= 0;
      end
    end
  end
endmodule

// [sim/nco_core_bench.sv]
// Self-checking bench for the note credit output block.
`include "nco_regs.vh"
module nco_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic note_present = 1'b0;
  logic transport_active = 1'b0;
  logic note_stacked = 1'b0;
  logic [3:0] note_chan = 4'h0;
  logic [3:0] channel_block_input = 4'h0;
  logic escrow_in = 1'b1;
  logic [31:0] reg_rdata_q;
  logic [15:0] chan_accept_q;
  logic [3:0] credit_line_n_q;
  logic bezel_on_q, motor_reverse_q, escrow_enable_q, busy_n_q, pulse_seen, rd_pend = 1'b0;
  logic [1:0] pulse_line;
  int pulse_width, num_errors = 0, num_checks = 0, e, v;
  logic [31:0] rd_q[$];
  int pw_q[$];

  always #2 sys_clk = ~sys_clk;

  nco_core #(.TICK_CYC(TICK)) nco_core_inst (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_q, .note_present, .transport_active, .note_stacked, .note_chan,
    .chan_accept_q, .bezel_on_q, .motor_reverse_q, .escrow_enable_q, .channel_block_input,
    .escrow_in, .credit_line_n_q, .busy_n_q);
  nco_host_model nco_host_model_inst (.sys_clk, .credit_line_n_q, .pulse_seen, .pulse_line,
    .pulse_width);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(x);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // Runs the transport a few cycles, then reports a stacked note.
  task automatic stack(input logic [3:0] ch, input int ln, input int n, input int w);
    repeat (n) pw_q.push_back(ln * 65536 + w);
    @(posedge sys_clk);
    transport_active <= 1'b1;
    repeat (3) @(posedge sys_clk);
    note_stacked <= 1'b1;
    note_chan <= ch;
    @(posedge sys_clk);
    note_stacked <= 1'b0;
    transport_active <= 1'b0;
  endtask
  task automatic drain(input bit idle, input int lim);
    int n;
    n = 0;
    while ((pw_q.size() != 0 || (idle && busy_n_q !== 1'b1)) && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk("drain limit", 1, n < lim);
    repeat (4) @(posedge sys_clk);
    chk("pending pulses", 0, pw_q.size());
  endtask
  task automatic toggle_escrow();
    escrow_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    escrow_in <= 1'b1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares read data and measured pulses against the oldest queued expectations.
  always @(posedge sys_clk) begin
    rd_pend <= reg_rd;
    if (rd_pend) chk("read data", rd_q.pop_front(), reg_rdata_q);
    if (pulse_seen) begin
      e = (pw_q.size() != 0) ? pw_q.pop_front() : -1;
      chk("pulse line", 32'(e >>> 16), 32'(pulse_line));
      chk("pulse width", 1, (pulse_width - e % 65536) inside {[-1:1]});
    end
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h85b6d6fe));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`NCO_A_CTRL, 32'h0000_0000);
    rd(`NCO_A_PLOW, 32'h0000_0032);
    rd(`NCO_A_PPD, 32'h0000_0001);
    rd(8'h20, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      stack(4'(c), c, 1, 100 * TICK);
      drain(1, 3000);
    end
    channel_block_input <= 4'h4;
    stack(4'h2, 0, 0, 0);
    stack(4'h5, 0, 0, 0);
    drain(1, 100);
    channel_block_input <= 4'hF;
    note_present <= 1'($urandom());
    repeat (2) @(posedge sys_clk);
    chk("motor reverse", note_present, motor_reverse_q);
    chk("bezel", 0, bezel_on_q);
    channel_block_input <= 4'h2;
    note_present <= 1'b0;
    v = $urandom_range(3, 1);
    wr(`NCO_A_PLOW, 32'h0000_0003);
    wr(`NCO_A_PHIGH, 32'h0000_0002);
    wr(`NCO_A_PPD, 32'h0000_0002);
    wr(`NCO_A_CHAN_BASE + 8'h14, 32'(v));
    wr(`NCO_A_CTRL, 32'h0000_0001);
    stack(4'h5, 0, 2 * v, 3 * TICK);
    drain(1, 2000);
    wr(`NCO_A_PRESET, 32'h0000_0050);
    rd(`NCO_A_PPD, 32'h0000_0003);
    rd(`NCO_A_PLOW, 32'h0000_0003);
    wr(`NCO_A_PRESET, 32'h0000_0003);
    rd(`NCO_A_PLOW, 32'h0000_0032);
    channel_block_input <= 4'h0;
    wr(`NCO_A_CTRL, 32'h0000_0003);
    stack(4'h1, 0, 0, 0);
    repeat (20) @(posedge sys_clk);
    chk("busy in hold", 0, busy_n_q);
    for (int g = 0; g < 2; g++) begin
      repeat (3) pw_q.push_back(50 * TICK);
      // Let the last high phase finish so the toggle falls inside the wait.
      repeat (3 * TICK) @(posedge sys_clk);
      rd(`NCO_A_STATUS, 32'h0000_0014 | (32'(2 - g) << 8));
      toggle_escrow();
      drain(0, 4000);
    end
    drain(1, 100);
    print_verdict();
  end
endmodule
